//--- gw_pkg.sv
// Shared constants and types of the gap-coded write link
// Assumes one clock mclk at 250 MHz on both ends
//
// Behaviour
// - Reader writes by gapping field; gaps delimit bits
// - First two bits after start gap: opcode 10
// - Next bit is the block lock flag
// - Next 32 bits are the data word
// - Last 3 bits select the block
// - Program only when bit count is exact
// - Gap restarts field clock counter; count decides bit
// - Count 16 to 32 decodes zero
// - Count 48 to 64 decodes one
// - Other counts: error, leave write mode
// - Count field clocks until gap actually detected
// - Reader uses recommended gap and interval times
// - Eight blocks of 33 bits, one written at once
// - Locked block is never overwritten
package gw_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int MCLK_NS = 4;
   localparam int FIELD_PERIOD_NS = 8000;
   localparam logic [10:0] TICK_DIV = 11'(FIELD_PERIOD_NS / MCLK_NS);
   localparam int ZERO_INTERVAL_TIME_US = 160;
   localparam int ONE_INTERVAL_TIME_US = 416;
   localparam int FIELD_OFF_DURATION_US = 160;
   localparam int DECAY_TIME_US = 32;
   localparam logic [6:0] ZERO_TICKS = 7'(ZERO_INTERVAL_TIME_US * 1000 / FIELD_PERIOD_NS);
   localparam logic [6:0] ONE_TICKS = 7'(ONE_INTERVAL_TIME_US * 1000 / FIELD_PERIOD_NS);
   localparam logic [6:0] GAP_TICKS = 7'(FIELD_OFF_DURATION_US * 1000 / FIELD_PERIOD_NS);
   localparam logic [6:0] DECAY_TICKS = 7'(DECAY_TIME_US * 1000 / FIELD_PERIOD_NS);
   localparam int PROG_TIME_NS = 16000000;
   localparam logic [21:0] PROG_CYC = 22'(PROG_TIME_NS / MCLK_NS);

   // ----------------------------------------
   // Interval decode windows
   // ----------------------------------------
   localparam logic [6:0] ZERO_MIN = 7'h10;
   localparam logic [6:0] ZERO_MAX = 7'h20;
   localparam logic [6:0] ONE_MIN = 7'h30;
   localparam logic [6:0] ONE_MAX = 7'h40;
   localparam logic [6:0] CNT_MAX = 7'h7F;

   // ----------------------------------------
   // Frame layout, first bit sent is bit 37
   // ----------------------------------------
   localparam logic [5:0] FRAME_BITS = 6'h26;
   localparam logic [5:0] NBITS_SAT = 6'h3F;
   localparam logic [1:0] OPCODE_WRITE = 2'h2;
   localparam int OP_MSB = 37;
   localparam int OP_LSB = 36;
   localparam int FR_LOCK = 35;
   localparam int FR_DATA_MSB = 34;
   localparam int FR_DATA_LSB = 3;
   localparam int FR_ADDR_MSB = 2;

   // ----------------------------------------
   // Block memory layout
   // ----------------------------------------
   localparam int NUM_BLOCKS = 8;
   localparam int BLK_LOCK = 32;
   localparam logic [32:0] BLK_RESET = 33'h000000000;

   // ----------------------------------------
   // Reader register map
   // ----------------------------------------
   localparam logic [4:0] REG_DATA = 5'h00;
   localparam logic [4:0] REG_CTRL = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h08;
   localparam logic [4:0] REG_IRQ_STAT = 5'h0C;
   localparam logic [4:0] REG_IRQ_MASK = 5'h10;
   localparam int CTRL_LOCK = 0;
   localparam int CTRL_ADDR_LSB = 1;
   localparam int CTRL_ADDR_MSB = 3;
   localparam int CTRL_GO = 8;
   localparam int IRQ_DONE = 0;

   // ----------------------------------------
   // State types
   // ----------------------------------------
   typedef enum logic [1:0] {
      TAG_READ = 2'b00,
      TAG_RX = 2'b01,
      TAG_PROG = 2'b10
   } gw_tag_state_e;

   typedef enum logic [1:0] {
      RDR_IDLE = 2'b00,
      RDR_GAP = 2'b01,
      RDR_ON = 2'b10
   } gw_rdr_state_e;

endpackage

//--- gw_link_if.sv
// Field link between reader end and tag end
// Assumes both ends run on mclk; reader drives, tag listens
`timescale 1ns/1ps
`default_nettype none
interface gw_link_if;
   // Field clock pulse, one mclk cycle per carrier period
   logic field_clk;
   // Gap detector level, high while field below threshold
   logic gap_det;

   modport reader (
      output field_clk,
      output gap_det
   );

   modport tag (
      input field_clk,
      input gap_det
   );
endinterface
`default_nettype wire

//--- gw_tag.sv
// Tag end: gap interval decoder, frame check, block memory
// Assumes link signals are produced on mclk by the reader end
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module gw_tag
   import gw_pkg::*;
#(
   parameter logic [21:0] PROG_CYCLES = PROG_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Field link
   gw_link_if.tag link,
   // Memory read port
   input wire logic [2:0] rd_addr,
   output logic [32:0] rd_data,
   // Status
   output logic write_mode,
   output logic programming,
   output logic wr_done,
   output logic wr_locked,
   output logic dec_err,
   output logic frame_bad,
   output logic [7:0] err_count
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      gw_tag_state_e st;
      logic gap_q;
      logic [6:0] cnt;
      logic [5:0] nbits;
      logic [37:0] shreg;
      logic [21:0] prog_cnt;
      logic [2:0] wr_addr;
      logic [32:0] wr_word;
      logic [NUM_BLOCKS-1:0][32:0] mem;
      logic [32:0] rd_data;
      logic write_mode;
      logic programming;
      logic wr_done;
      logic wr_locked;
      logic dec_err;
      logic frame_bad;
      logic [7:0] err_count;
   } gw_tag_s;

   gw_tag_s r;
   gw_tag_s next_r;
   logic gap_evt;
   logic [1:0] sym;
   logic frame_ok;
   logic [2:0] fr_addr;

   // ----------------------------------------
   // Interval classifier
   // ----------------------------------------
   // Returns 0 for zero, 1 for one, 2 for error
   function automatic logic [1:0] classify(input logic [6:0] c);
      if (c >= ZERO_MIN && c <= ZERO_MAX) begin
         classify = 2'h0;
      end else if (c >= ONE_MIN && c <= ONE_MAX) begin
         classify = 2'h1;
      end else begin
         classify = 2'h2;
      end
   endfunction

   // Saturating increment of the error count
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      if (v == 8'hFF) begin
         sat_inc = v;
      end else begin
         sat_inc = v + 8'h01;
      end
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_r = r;
      next_r.gap_q = link.gap_det;
      next_r.wr_done = 1'b0;
      next_r.wr_locked = 1'b0;
      next_r.dec_err = 1'b0;
      next_r.frame_bad = 1'b0;
      next_r.rd_data = r.mem[rd_addr];
      gap_evt = link.gap_det & ~r.gap_q;
      sym = classify(r.cnt);
      fr_addr = r.shreg[FR_ADDR_MSB:0];
      frame_ok = (r.nbits == FRAME_BITS)
         && (r.shreg[OP_MSB:OP_LSB] == OPCODE_WRITE);

      // Field clocks counted until the detector fires
      if (link.field_clk && r.cnt != CNT_MAX) begin
         next_r.cnt = r.cnt + 7'h01;
      end

      case (r.st)
         TAG_READ: begin
            if (gap_evt) begin
               next_r.st = TAG_RX;
               next_r.cnt = 7'h00;
               next_r.nbits = 6'h00;
               next_r.write_mode = 1'b1;
            end
         end

         TAG_RX: begin
            if (gap_evt) begin
               next_r.cnt = 7'h00;
               if (sym == 2'h2) begin
                  next_r.st = TAG_READ;
                  next_r.write_mode = 1'b0;
                  next_r.dec_err = 1'b1;
                  next_r.err_count = sat_inc(r.err_count);
               end else begin
                  next_r.shreg = {r.shreg[36:0], sym[0]};
                  if (r.nbits != NBITS_SAT) begin
                     next_r.nbits = r.nbits + 6'h01;
                  end
               end
            end else if (r.cnt > ONE_MAX) begin
               // No further gap: the frame has ended
               next_r.st = TAG_READ;
               next_r.write_mode = 1'b0;
               if (!frame_ok) begin
                  next_r.frame_bad = 1'b1;
               end else if (r.mem[fr_addr][BLK_LOCK]) begin
                  next_r.wr_locked = 1'b1;
               end else begin
                  next_r.st = TAG_PROG;
                  next_r.programming = 1'b1;
                  next_r.prog_cnt = PROG_CYCLES;
                  next_r.wr_addr = fr_addr;
                  next_r.wr_word = {r.shreg[FR_LOCK],
                     r.shreg[FR_DATA_MSB:FR_DATA_LSB]};
               end
            end
         end

         TAG_PROG: begin
            // Gaps are ignored while the block is programmed
            if (r.prog_cnt > 22'h000001) begin
               next_r.prog_cnt = r.prog_cnt - 22'h000001;
            end else begin
               next_r.mem[r.wr_addr] = r.wr_word;
               next_r.st = TAG_READ;
               next_r.programming = 1'b0;
               next_r.wr_done = 1'b1;
            end
         end

         default: begin
            next_r.st = TAG_READ;
            next_r.write_mode = 1'b0;
            next_r.programming = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r.st <= TAG_READ;
         r.gap_q <= 1'b0;
         r.cnt <= 7'h00;
         r.nbits <= 6'h00;
         r.shreg <= 38'h0000000000;
         r.prog_cnt <= 22'h000000;
         r.wr_addr <= 3'h0;
         r.wr_word <= BLK_RESET;
         r.mem <= {NUM_BLOCKS{BLK_RESET}};
         r.rd_data <= BLK_RESET;
         r.write_mode <= 1'b0;
         r.programming <= 1'b0;
         r.wr_done <= 1'b0;
         r.wr_locked <= 1'b0;
         r.dec_err <= 1'b0;
         r.frame_bad <= 1'b0;
         r.err_count <= 8'h00;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rd_data = r.rd_data;
   assign write_mode = r.write_mode;
   assign programming = r.programming;
   assign wr_done = r.wr_done;
   assign wr_locked = r.wr_locked;
   assign dec_err = r.dec_err;
   assign frame_bad = r.frame_bad;
   assign err_count = r.err_count;

endmodule // gw_tag
`default_nettype wire

//--- gw_reader.sv
// Reader end: register port, gap-coded frame transmitter
// Assumes a software master on mclk and the tag end on the link
`timescale 1ns/1ps
`default_nettype none
module gw_reader
   import gw_pkg::*;
#(
   // Field clock divider in mclk cycles
   parameter logic [10:0] TICK_CYCLES = TICK_DIV
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [4:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Interrupt
   output logic irq,
   // Field link
   gw_link_if.reader link
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      gw_rdr_state_e st;
      logic [10:0] div;
      logic [6:0] ph;
      logic [37:0] frame;
      logic [5:0] left;
      logic [31:0] data;
      logic lock;
      logic [2:0] baddr;
      logic done_st;
      logic done_mask;
      logic [31:0] rdata;
      logic irq;
      logic field_clk;
      logic gap_det;
   } gw_rdr_s;

   gw_rdr_s r;
   gw_rdr_s next_r;
   logic tick;
   logic [6:0] on_len;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_r = r;
      next_r.field_clk = 1'b0;
      next_r.rdata = 32'h00000000;
      tick = (r.div == 11'h000);
      next_r.div = tick ? TICK_CYCLES - 11'h001 : r.div - 11'h001;
      on_len = r.frame[OP_MSB] ? ONE_TICKS : ZERO_TICKS;

      if (wr) begin
         case (addr)
            REG_DATA: next_r.data = wdata;
            REG_CTRL: begin
               next_r.lock = wdata[CTRL_LOCK];
               next_r.baddr = wdata[CTRL_ADDR_MSB:CTRL_ADDR_LSB];
               if (wdata[CTRL_GO] && r.st == RDR_IDLE) begin
                  next_r.frame = {OPCODE_WRITE, wdata[CTRL_LOCK],
                     r.data, wdata[CTRL_ADDR_MSB:CTRL_ADDR_LSB]};
                  next_r.left = FRAME_BITS;
                  next_r.ph = 7'h00;
                  next_r.st = RDR_GAP;
               end
            end
            REG_IRQ_STAT: next_r.done_st = r.done_st & ~wdata[IRQ_DONE];
            REG_IRQ_MASK: next_r.done_mask = wdata[IRQ_DONE];
            default: ;
         endcase
      end

      if (rd) begin
         case (addr)
            REG_DATA: next_r.rdata = r.data;
            REG_CTRL: next_r.rdata = {28'h0000000, r.baddr, r.lock};
            REG_STATUS: next_r.rdata = {31'h00000000, r.st != RDR_IDLE};
            REG_IRQ_STAT: next_r.rdata = {31'h00000000, r.done_st};
            REG_IRQ_MASK: next_r.rdata = {31'h00000000, r.done_mask};
            default: next_r.rdata = 32'h00000000;
         endcase
      end

      case (r.st)
         RDR_IDLE: begin
            next_r.field_clk = tick;
         end

         RDR_GAP: begin
            // Field off: decay pulses, then detector high
            if (tick) begin
               next_r.ph = r.ph + 7'h01;
               next_r.field_clk = (r.ph < DECAY_TICKS);
               if (r.ph == DECAY_TICKS) begin
                  next_r.gap_det = 1'b1;
               end
               if (r.ph == DECAY_TICKS + GAP_TICKS - 7'h01) begin
                  next_r.gap_det = 1'b0;
                  next_r.ph = 7'h00;
                  if (r.left == 6'h00) begin
                     next_r.st = RDR_IDLE;
                     next_r.done_st = 1'b1;
                  end else begin
                     next_r.st = RDR_ON;
                  end
               end
            end
         end

         RDR_ON: begin
            if (tick) begin
               next_r.field_clk = 1'b1;
               next_r.ph = r.ph + 7'h01;
               if (r.ph == on_len - 7'h01) begin
                  next_r.ph = 7'h00;
                  next_r.frame = {r.frame[36:0], 1'b0};
                  next_r.left = r.left - 6'h01;
                  next_r.st = RDR_GAP;
               end
            end
         end

         default: next_r.st = RDR_IDLE;
      endcase

      next_r.irq = next_r.done_st & next_r.done_mask;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r.st <= RDR_IDLE;
         r.div <= 11'h000;
         r.ph <= 7'h00;
         r.frame <= 38'h0000000000;
         r.left <= 6'h00;
         r.data <= 32'h00000000;
         r.lock <= 1'b0;
         r.baddr <= 3'h0;
         r.done_st <= 1'b0;
         r.done_mask <= 1'b0;
         r.rdata <= 32'h00000000;
         r.irq <= 1'b0;
         r.field_clk <= 1'b0;
         r.gap_det <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata = r.rdata;
   assign irq = r.irq;
   assign link.field_clk = r.field_clk;
   assign link.gap_det = r.gap_det;

endmodule // gw_reader
`default_nettype wire

//--- gw_link_props.sv
// Checker for the reader-to-tag field link and tag status
// Assumes instantiation beside the link joining the two ends
`timescale 1ns/1ps
`default_nettype none
module gw_link_props
   import gw_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Field link
   input wire logic field_clk,
   input wire logic gap_det,
   // Tag status
   input wire logic write_mode,
   input wire logic programming,
   input wire logic wr_done,
   input wire logic dec_err
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Link shape
   // ----------------------------------------
   a_fclk_pulse: assert property (field_clk |=> !field_clk)
      else $error("field clock pulse longer than one cycle");
   a_gap_quiet: assert property (gap_det |-> !field_clk)
      else $error("field clock seen during gap");
   a_gap_hold: assert property ($rose(gap_det) |=> gap_det [*8])
      else $error("gap shorter than eight cycles");

   // ----------------------------------------
   // Tag response
   // ----------------------------------------
   a_gap_enter: assert property ($rose(gap_det) && !programming |=> write_mode || dec_err)
      else $error("gap event did not start or continue a frame");
   a_err_drop: assert property (dec_err |-> ##[0:1] !write_mode)
      else $error("write mode kept after decode error");
   a_err_pulse: assert property (dec_err |=> !dec_err)
      else $error("decode error pulse too long");
   a_prog_excl: assert property (programming |-> !write_mode)
      else $error("write mode during programming");
   a_prog_deaf: assert property (programming && $rose(gap_det) |=> !write_mode)
      else $error("gap accepted during programming");
   a_done_after: assert property (wr_done |-> $past(programming))
      else $error("block written without programming phase");
   a_done_pulse: assert property (wr_done |=> !wr_done)
      else $error("write done pulse too long");
endmodule // gw_link_props
`default_nettype wire

//--- testbench.sv
// Testbench: reader and tag joined by one link, second tag driven directly
// Assumes gw_pkg, gw_link_if, gw_reader, gw_tag and gw_link_props compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module testbench
   import gw_pkg::*;
;
   logic mclk, rst, wr, rd, irq, wm1, pg1, wd1, de1;
   logic [4:0] addr;
   logic [31:0] wdata, rdata;
   logic [2:0] rd_addr;
   logic [32:0] rd_data, rd_data1;
   logic write_mode, programming, wr_done, wr_locked, dec_err, frame_bad;
   logic [7:0] err_count;
   int errors = 0, compares = 0, n_done = 0, n_lock = 0, n_bad = 0, n_err = 0;

   gw_link_if link1();
   gw_link_if link2();
   gw_reader #(.TICK_CYCLES(11'h002)) gw_reader_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .link(link1));
   gw_tag #(.PROG_CYCLES(22'h00000A)) gw_tag_i (.mclk(mclk), .rst(rst), .link(link1), .rd_addr(rd_addr),
      .rd_data(rd_data1), .write_mode(wm1), .programming(pg1), .wr_done(wd1), .wr_locked(), .dec_err(de1),
      .frame_bad(), .err_count());
   gw_tag #(.PROG_CYCLES(22'h00000A)) gw_tag_i2 (.mclk(mclk), .rst(rst), .link(link2), .rd_addr(rd_addr),
      .rd_data(rd_data), .write_mode(write_mode), .programming(programming), .wr_done(wr_done),
      .wr_locked(wr_locked), .dec_err(dec_err), .frame_bad(frame_bad), .err_count(err_count));
   gw_link_props gw_link_props_i (.mclk(mclk), .rst(rst), .field_clk(link1.field_clk),
      .gap_det(link1.gap_det), .write_mode(wm1), .programming(pg1), .wr_done(wd1), .dec_err(de1));

   // ----------------------------------------
   // Clock and event counters
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (wr_done === 1'b1) n_done++;
      if (wr_locked === 1'b1) n_lock++;
      if (frame_bad === 1'b1) n_bad++;
      if (dec_err === 1'b1) n_err++;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task conclude;
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task reg_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task reg_chk(input logic [4:0] a, input logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask
   task pulses(input int n);
      repeat (n) begin
         @(posedge mclk);
         link2.field_clk <= 1'b1;
         @(posedge mclk);
         link2.field_clk <= 1'b0;
      end
   endtask
   task gap;
      @(posedge mclk);
      link2.gap_det <= 1'b1;
      repeat (4) @(posedge mclk);
      link2.gap_det <= 1'b0;
   endtask
   task settle;
      int k;
      k = 0;
      while ((write_mode !== 1'b0 || programming !== 1'b0) && k < 300) begin
         @(posedge mclk);
         k++;
      end
      `CHK(k < 300, 1'b1)
      if (k >= 300) conclude();
      repeat (3) @(posedge mclk);
   endtask
   // Counts alternate between window edges: zero 16/32, one 48/64
   task send(input logic [37:0] f, input int nb);
      gap();
      for (int i = 37; i > 37 - nb; i--) begin
         pulses(f[i] ? (i % 2 ? 64 : 48) : (i % 2 ? 32 : 16));
         gap();
      end
      pulses(70);
      settle();
   endtask
   task err_case(input int n);
      gap();
      pulses(n);
      gap();
      pulses(70);
      settle();
   endtask
   task blk(input logic [2:0] a, input logic [32:0] e);
      @(posedge mclk);
      rd_addr <= a;
      repeat (2) @(posedge mclk);
      #1;
      `CHK(rd_data, e)
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int k;
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 5'h00;
      wdata = 32'h0;
      rd_addr = 3'h0;
      link2.field_clk = 1'b0;
      link2.gap_det = 1'b0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      reg_wr(REG_DATA, 32'h5A3C96E1);
      reg_chk(REG_DATA, 32'h5A3C96E1);
      reg_chk(REG_STATUS, 32'h0);
      reg_wr(REG_IRQ_MASK, 32'h1);
      reg_chk(REG_IRQ_MASK, 32'h1);
      reg_chk(REG_IRQ_STAT, 32'h0);
      reg_chk(5'h1C, 32'h0);
      reg_wr(REG_CTRL, 32'h0000000B);
      reg_chk(REG_CTRL, 32'h0000000B);
      `CHK(irq, 1'b0)
      reg_wr(REG_CTRL, 32'h0000010B);
      reg_chk(REG_STATUS, 32'h1);
      reg_chk(REG_CTRL, 32'h0000000B);
      k = 0;
      while (wm1 !== 1'b1 && k < 20000) begin
         @(posedge mclk);
         k++;
      end
      `CHK(wm1, 1'b1)
      `CHK(link1.gap_det, 1'b1)
      if (k >= 20000) conclude();
      send({2'b10, 1'b0, 32'hA5C30F96, 3'h5}, 38);
      `CHK(n_done, 1)
      blk(3'h5, {1'b0, 32'hA5C30F96});
      blk(3'h4, 33'h0);
      send({2'b10, 1'b1, 32'h01234567, 3'h2}, 38);
      blk(3'h2, {1'b1, 32'h01234567});
      send({2'b10, 1'b0, 32'hFFFFFFFF, 3'h2}, 38);
      `CHK(n_lock, 1)
      blk(3'h2, {1'b1, 32'h01234567});
      for (int op = 0; op < 4; op++)
         if (op != 2) send({2'(op), 1'b0, 32'h3C3C3C3C, 3'h1}, 38);
      send({2'b10, 1'b0, 32'h3C3C3C3C, 3'h1}, 37);
      `CHK(n_bad, 4)
      blk(3'h1, 33'h0);
      err_case(15);
      err_case(33);
      err_case(47);
      `CHK(n_err, 3)
      `CHK(err_count, 8'h03)
      send({2'b10, 1'b0, 32'h0F0F0F0F, 3'h7}, 38);
      blk(3'h7, {1'b0, 32'h0F0F0F0F});
      `CHK(n_done, 3)
      blk(3'h5, {1'b0, 32'hA5C30F96});
      `CHK(rd_data1, {1'b1, 32'h5A3C96E1})
      `CHK(irq, 1'b1)
      reg_chk(REG_STATUS, 32'h0);
      reg_chk(REG_IRQ_STAT, 32'h1);
      reg_wr(REG_IRQ_STAT, 32'h1);
      reg_chk(REG_IRQ_STAT, 32'h0);
      `CHK(irq, 1'b0)
      conclude();
   end
endmodule // testbench
`default_nettype wire
